/* hdl/gauge_driver_spi_slave.sv */
// Purpose: serial slave front end of a dual stepper-gauge driver
// Assumes: sclk is the link clock and idles low; cs_n pulled high when idle
// Notes:   shift logic runs on sclk; word transfer runs on core_clk
//
// How it works
// - words are 16 bits each way, most significant bit first on both lines.
// - when chip select rises, the last received word goes into the addressed register.
// - the serial output is driven only while chip select is low.
// - with chip select high, clock and data activity is ignored and nothing shifts.
// - serial input is sampled on every falling serial clock edge.
// - serial output changes on every rising serial clock edge after the first of a frame.
// - a frame whose bit count is not a multiple of 16 is dropped without any write.
// - a frame first returns 16 status bits, then the bits it received, in order.
// - the first rising clock edge of a frame loads the selected status word.
// - the destination register is chosen by the top three bits of the word.
// - addresses 0 to 5 pick the six control registers; 6 is unused, 7 is test.
// - several words may share a frame if the total is a multiple of 16; the last is kept.
module gauge_driver_spi_slave
  import gauge_spi_pkg::*;
(
  // core clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     srst,
  // serial link
  input  wire logic                     sclk,
  input  wire logic                     cs_n,
  input  wire logic                     si,
  output logic                          so_o,
  output logic                          so_oe,
  // status word to report, core domain
  input  wire logic [15:0]              status_word,
  // register contents and write pulses, core domain
  output gauge_spi_pkg::ctrl_regs_t     ctrl_regs,
  output gauge_spi_pkg::write_strobes_t write_strobes,
  output logic                          frame_dropped
);
  import gauge_spi_pkg::*;

  // link domain: receive side on falling sclk
  logic [WORD_W-1:0] rx_shift;
  logic [CNT_W-1:0]  rx_count;
  logic              rx_any;

  // cs_n acts as asynchronous clear so the counters restart each frame
  // without relying on sclk edges outside frames
  always_ff @(negedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      rx_count <= '0;
      rx_any   <= 1'b0;
    end
    else
    begin
      rx_count <= rx_count + 4'h1;
      rx_any   <= 1'b1;
    end
  end

  // shift register keeps its contents past the frame end for the core to copy
  always_ff @(negedge sclk)
  begin
    if (!cs_n)
    begin
      rx_shift <= {rx_shift[WORD_W-2:0], si};
    end
  end

  // verdict snapshot on the rising chip select, before the counters clear
  logic frame_good;

  always_ff @(posedge cs_n)
  begin
    frame_good <= rx_any && (rx_count == '0);
  end

  // link domain: transmit side on rising sclk
  logic [WORD_W-1:0] tx_shift;
  logic              tx_loaded;
  logic              tx_bit;
  logic [WORD_W-1:0] rx_fifo;

  // status word held stable in core domain while cs_n is low
  logic [WORD_W-1:0] status_hold;

  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      tx_loaded <= 1'b0;
    end
    else
    begin
      tx_loaded <= 1'b1;
    end
  end

  // the output shifter runs the status word then the received bits:
  // each rising edge after the first shifts in the bit captured on the previous falling edge
  always_ff @(posedge sclk)
  begin
    if (!cs_n)
    begin
      if (!tx_loaded)
      begin
        tx_shift <= status_hold;
      end
      else
      begin
        tx_shift <= {tx_shift[WORD_W-2:0], rx_shift[0]};
      end
    end
  end

  // first bit of a frame appears as soon as cs_n falls, before any edge
  assign tx_bit  = tx_loaded ? tx_shift[WORD_W-1] : status_hold[WORD_W-1];
  assign so_o    = tx_bit;
  assign so_oe   = ~cs_n;
  assign rx_fifo = rx_shift;

  // core domain: cs_n level through the synchroniser
  logic cs_n_sync;
  logic cs_n_prev;

  level_sync u_cs_sync
  (
    .clk      (core_clk),
    .srst     (srst),
    .async_in (cs_n),
    .sync_out (cs_n_sync)
  );

  // the status word is frozen whenever a frame may be running, so the
  // link side reads a quiet register; it refreshes only while cs_n is high
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      status_hold <= 16'h0000;
    end
    else if (cs_n_sync && cs_n_prev)
    begin
      status_hold <= status_word;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      cs_n_prev <= 1'b1;
    end
    else
    begin
      cs_n_prev <= cs_n_sync;
    end
  end

  logic rise_cs;
  assign rise_cs = cs_n_sync && !cs_n_prev;

  // frame end: rx_shift and frame_good are frozen while cs_n stays high,
  // so they are safe to read once the synchronised rise is seen; the
  // master must keep cs_n high for that long
  xfer_state_t       state;
  xfer_state_t       next_state;
  logic [WORD_W-1:0] word_cap;
  logic              word_ok;

  always_comb
  begin
    next_state = state;
    case (state)
      XFER_IDLE:
        if (rise_cs)
          next_state = XFER_APPLY;
      XFER_APPLY:
        next_state = XFER_IDLE;
      default:
        next_state = XFER_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      state <= XFER_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      word_cap <= 16'h0000;
    end
    else if (rise_cs)
    begin
      word_cap <= rx_fifo;
    end
  end

  // the link values are frozen by now; only the synchronised rise crosses
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      word_ok <= 1'b0;
    end
    else if (rise_cs)
    begin
      word_ok <= frame_good;
    end
  end

  logic [2:0]        addr;
  logic [DATA_W-1:0] data;
  logic              apply;
  assign addr  = word_cap[ADDR_MSB:ADDR_LSB];
  assign data  = word_cap[DATA_W-1:0];
  assign apply = (state == XFER_APPLY) && word_ok;

  // one register per address; six and seven match none, so they write nothing
  logic [DATA_W-1:0] power_enable_cal_config;
  logic [DATA_W-1:0] max_velocity;
  logic [DATA_W-1:0] gauge0_target_position;
  logic [DATA_W-1:0] gauge1_target_position;
  logic [DATA_W-1:0] return_to_zero_command;
  logic [DATA_W-1:0] return_to_zero_config;

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      power_enable_cal_config <= REG_RESET;
    end
    else if (apply && addr == ADDR_POWER_ENABLE_CAL_CONFIG)
    begin
      power_enable_cal_config <= data;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      max_velocity <= REG_RESET;
    end
    else if (apply && addr == ADDR_MAX_VELOCITY)
    begin
      max_velocity <= data;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      gauge0_target_position <= REG_RESET;
    end
    else if (apply && addr == ADDR_GAUGE0_TARGET_POSITION)
    begin
      gauge0_target_position <= data;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      gauge1_target_position <= REG_RESET;
    end
    else if (apply && addr == ADDR_GAUGE1_TARGET_POSITION)
    begin
      gauge1_target_position <= data;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      return_to_zero_command <= REG_RESET;
    end
    else if (apply && addr == ADDR_RETURN_TO_ZERO_COMMAND)
    begin
      return_to_zero_command <= data;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      return_to_zero_config <= REG_RESET;
    end
    else if (apply && addr == ADDR_RETURN_TO_ZERO_CONFIG)
    begin
      return_to_zero_config <= data;
    end
  end

  // the six registers leave as one carrier, address zero in the top field
  assign ctrl_regs = {power_enable_cal_config,
                      max_velocity,
                      gauge0_target_position,
                      gauge1_target_position,
                      return_to_zero_command,
                      return_to_zero_config};

  // one-cycle write pulses let the motion logic act on new settings
  always_ff @(posedge core_clk)
  begin
    if (srst)
      write_strobes <= '0;
    else
    begin
      write_strobes <= '0;
      if (apply && addr <= ADDR_RETURN_TO_ZERO_CONFIG)
      begin
        write_strobes.written[addr] <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      frame_dropped <= 1'b0;
    end
    else
    begin
      frame_dropped <= (state == XFER_APPLY) && !word_ok;
    end
  end

endmodule : gauge_driver_spi_slave

/* hdl/gauge_spi_pkg.sv */
// Purpose: shared constants and types for the gauge driver serial front end
// Assumes: 16-bit words, three address bits on top of each word
// Notes:   register contents are carried opaque, thirteen data bits each
package gauge_spi_pkg;

  localparam int WORD_W       = 16;
  localparam int DATA_W       = 13;
  localparam int ADDR_MSB     = 15;
  localparam int ADDR_LSB     = 13;
  localparam int CNT_W        = 4;
  localparam int SYNC_STAGES  = 3;

  // register addresses in the top three bits of a word
  localparam logic [2:0] ADDR_POWER_ENABLE_CAL_CONFIG = 3'h0;
  localparam logic [2:0] ADDR_MAX_VELOCITY            = 3'h1;
  localparam logic [2:0] ADDR_GAUGE0_TARGET_POSITION  = 3'h2;
  localparam logic [2:0] ADDR_GAUGE1_TARGET_POSITION  = 3'h3;
  localparam logic [2:0] ADDR_RETURN_TO_ZERO_COMMAND  = 3'h4;
  localparam logic [2:0] ADDR_RETURN_TO_ZERO_CONFIG   = 3'h5;
  localparam logic [2:0] ADDR_UNUSED                  = 3'h6;
  localparam logic [2:0] ADDR_TEST_RESERVED           = 3'h7;

  localparam logic [12:0] REG_RESET = 13'h0000;

  typedef struct packed {
    logic [12:0] power_enable_cal_config;
    logic [12:0] max_velocity;
    logic [12:0] gauge0_target_position;
    logic [12:0] gauge1_target_position;
    logic [12:0] return_to_zero_command;
    logic [12:0] return_to_zero_config;
  } ctrl_regs_t;

  typedef struct packed {
    logic [5:0] written;
  } write_strobes_t;

  typedef enum logic [1:0] {
    XFER_IDLE  = 2'b00,
    XFER_APPLY = 2'b01
  } xfer_state_t;

endpackage : gauge_spi_pkg

/* hdl/level_sync.sv */
// Purpose: three-stage synchroniser with agreement filter for one level
// Assumes: input is asynchronous to clk
// Notes:   output changes only once stages two and three agree
module level_sync
(
  // clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // level
  input  wire logic async_in,
  output logic      sync_out
);

  logic s1;
  logic s2;
  logic s3;

  // reset to the idle high level of chip select, so no false edge follows reset
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
    end
    else
    begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // s1 feeds only s2; the filter watches s2 and s3
  always_ff @(posedge clk)
  begin
    if (srst)
      sync_out <= 1'b1;
    else if (s2 == s3)
      sync_out <= s3;
  end

endmodule : level_sync

/* tb/gauge_driver_spi_slave_properties.sv */
// Purpose: port assertions for the gauge serial front end
// Assumes: status_word is held steady while a frame runs
// Notes:   all checks on core_clk; sclk is seen as a sampled level
module gauge_driver_spi_slave_properties
  import gauge_spi_pkg::*;
(
  // core clock and reset
  input wire logic                          core_clk,
  input wire logic                          srst,
  // serial link
  input wire logic                          sclk,
  input wire logic                          cs_n,
  input wire logic                          si,
  input wire logic                          so_o,
  input wire logic                          so_oe,
  // core side
  input wire logic [15:0]                   status_word,
  input wire gauge_spi_pkg::ctrl_regs_t     ctrl_regs,
  input wire gauge_spi_pkg::write_strobes_t write_strobes,
  input wire logic                          frame_dropped
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (srst);
  wire wr = |write_strobes.written;

  chk_oe_cs: assert property (so_oe == !cs_n) else $error("so enable off");
  chk_one_dest: assert property ($onehot0(write_strobes.written)) else $error("two strobes");
  chk_drop_quiet: assert property (frame_dropped |-> !wr) else $error("write on drop");
  chk_regs_hold: assert property (!wr |-> $stable(ctrl_regs)) else $error("stray change");
  chk_pulse_short: assert property (wr || frame_dropped |=> !wr && !frame_dropped)
    else $error("long pulse");
  chk_commit_idle: assert property (wr || frame_dropped |-> cs_n && $past(cs_n, 4))
    else $error("commit too early");
  chk_so_rise: assert property (so_oe && $past(so_oe) && !$rose(sclk) |-> $stable(so_o))
    else $error("so moved off rise");
  chk_first_stat: assert property ($fell(cs_n) |-> so_o == status_word[15])
    else $error("first bit not status");
  cov_write: cover property (wr);
  cov_drop: cover property (frame_dropped);
  cov_frame: cover property ($fell(cs_n) ##[1:200] $rose(cs_n));
endmodule : gauge_driver_spi_slave_properties

bind gauge_driver_spi_slave gauge_driver_spi_slave_properties i_props (.core_clk, .srst,
  .sclk, .cs_n, .si, .so_o, .so_oe, .status_word, .ctrl_regs, .write_strobes, .frame_dropped);

/* tb/gauge_driver_spi_slave_tb_top.sv */
// Purpose: self-checking bench for the gauge serial front end
// Assumes: master model frames words; core sees results as strobes
// Notes:   expected writes queue up and are matched as strobes appear
module gauge_driver_spi_slave_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import gauge_spi_pkg::*;
  logic           core_clk, srst, sclk, cs_n, si, so_o, so_oe, frame_dropped;
  logic [15:0]    status_word;
  ctrl_regs_t     ctrl_regs;
  write_strobes_t write_strobes;
  wire            so_line = so_oe ? so_o : 1'bz;
  logic [16:0]    exp_q[$];
  logic [16:0]    obs;
  logic [47:0]    d;
  logic [31:0]    seed = 32'h18F65E67;
  int             ns[6] = '{32, 48, 15, 17, 1, 0};
  int             fail_count = 0;
  int             n_checks = 0;

  gauge_driver_spi_slave i_dut (.core_clk, .srst, .sclk, .cs_n, .si, .so_o, .so_oe,
    .status_word, .ctrl_regs, .write_strobes, .frame_dropped);
  gauge_spi_master_model i_master (.sclk, .cs_n, .si, .so(so_line));

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    for (int k = 0; k < 32; k++)
      s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    return s;
  endfunction : lfsr

  task automatic chk_word(input logic [16:0] e, input logic [16:0] o);
    n_checks++;
    if (o !== e)
    begin
      fail_count++;
      $display("BAD %0t %h %h", $time, e, o);
    end
  endtask : chk_word

  task automatic chk_so(input logic [47:0] e, input logic [47:0] o);
    n_checks++;
    if (o !== e)
    begin
      fail_count++;
      $display("BAD %0t %h %h", $time, e, o);
    end
  endtask : chk_so

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  // status set well before the frame so the hold register has refreshed
  task automatic frame(input int n, input bit hi);
    logic [47:0] q;
    logic [63:0] e;
    @(posedge core_clk);
    #1 status_word = seed[31:16];
    repeat (12) @(posedge core_clk);
    e = ((64'(status_word) << n) | (64'(d) & ((64'h1 << n) - 64'h1))) >> 16;
    if (!hi && (n % 16 != 0 || n == 0))
      exp_q.push_back(17'h10000);
    else if (!hi && d[15:13] < 3'h6)
      exp_q.push_back({1'b0, d[15:0]});
    #1 i_master.xfer(d, n, hi, q);
    if (!hi)
      chk_so(e[47:0], q);
    $display("frame of %0d bits done", n);
  endtask : frame

  // a strobe with nothing queued meets an impossible note and fails
  always @(posedge core_clk)
    if (srst === 1'b0 && (write_strobes.written !== 6'h00 || frame_dropped === 1'b1))
    begin
      obs = {frame_dropped, 16'h0000};
      for (int a = 0; a < 6; a++)
        if (write_strobes.written[a] === 1'b1)
          obs = {1'b0, 3'(a), ctrl_regs[77 - 13 * a -: 13]};
      if (exp_q.size() == 0)
        chk_word(17'h1FFFF, obs);
      else
        chk_word(exp_q.pop_front(), obs);
    end

  initial
  begin
    srst = 1'b1;
    status_word = 16'h0000;
    d = 48'h0;
    repeat (16) @(posedge core_clk);
    #1 srst = 1'b0;
    frame(16, 1'b1);
    for (int i = 0; i < 14; i++)
    begin
      seed = lfsr(seed);
      d = {seed, seed[15:0]};
      if (i < 8)
        d[15:13] = 3'(i);
      frame(i < 8 ? 16 : ns[i - 8], 1'b0);
    end
    repeat (20) @(posedge core_clk);
    chk_word(17'h00000, 17'(exp_q.size()));
    close_out();
  end

  initial
  begin
    #200000;
    fail_count++;
    close_out();
  end
endmodule : gauge_driver_spi_slave_tb_top

/* tb/gauge_spi_master_model.sv */
// Purpose: serial master that frames words towards the gauge front end
// Assumes: sclk pulled low and cs_n pulled high when idle
// Notes:   32 ns link period; si inverted when released, no pull on it
module gauge_spi_master_model
(
  // serial link
  output logic      sclk,
  output logic      cs_n,
  output logic      si,
  input  wire logic so
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // hi keeps cs_n up so the clocks land outside any frame
  task automatic xfer(input logic [47:0] d, input int n, input bit hi, output logic [47:0] q);
    q = 48'h0;
    cs_n = hi;
    #20;
    for (int i = n - 1; i >= 0; i--)
    begin
      si = d[i];
      #8 sclk = 1'b1;
      #16 sclk = 1'b0;
      q[i] = so;
      #8;
    end
    #20 cs_n = 1'b1;
    si = ~si;
  endtask : xfer
endmodule : gauge_spi_master_model
